// ===== pkg/scl_map.svh
// Offsets, reset values, EEPROM word numbers and timing counts of the configuration loader
// What this block does
// - Auto-load EEPROM words 0 to 4 at power-on, after reading words 0 to 7
// - Word 0 to 0140h/0141h, default 0C08h
// - Word 1 to 0150h/0151h, default 6608h
// - Word 2 to 0982h/0983h, default 01F4h
// - Word 3 to 0152h/0153h, default 0000h
// - Word 4 to 0012h/0013h, default 0000h
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH

// Byte addresses of the low byte of each register pair
`define SCL_ADDR_IFCTL   16'h0140
`define SCL_ADDR_IFCFG   16'h0150
`define SCL_ADDR_SYNCLEN 16'h0982
`define SCL_ADDR_IFEXT   16'h0152
`define SCL_ADDR_ALIAS   16'h0012

// Hardware reset values
`define SCL_RST_IFCTL    16'h0c08
`define SCL_RST_IFCFG    16'h6608
`define SCL_RST_SYNCLEN  16'h01f4
`define SCL_RST_IFEXT    16'h0000
`define SCL_RST_ALIAS    16'h0000

// EEPROM word numbers
`define SCL_WORD_FIRST   3'h0
`define SCL_WORD_COPIED  3'h5
`define SCL_WORD_LAST    3'h7

// Answer timeout for one EEPROM word read
`define SCL_CLK_PERIOD_NS   40
`define SCL_ACK_TIMEOUT_NS  100000
`define SCL_ACK_TIMEOUT_CYC (`SCL_ACK_TIMEOUT_NS / `SCL_CLK_PERIOD_NS)

`endif

// ===== pkg/scl_pkg.sv
// Types shared by the configuration loader files
package scl_pkg;

  // Word read request towards the EEPROM reader
  typedef struct packed {
    logic       valid;
    logic [5:0] addr;
  } scl_ee_req_t;

  // Answer from the EEPROM reader
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] data;
  } scl_ee_rsp_t;

  // Loader sequence
  typedef enum logic [1:0] {
    ST_ISSUE,
    ST_WAIT,
    ST_DONE,
    ST_FAIL
  } scl_state_t;

endpackage

// ===== design/scl_cfg_slot.sv
// One configuration register that takes a loaded word or keeps its reset value
`timescale 1ns/1ps
module scl_cfg_slot #(
  parameter logic [15:0] RESET = 16'h0000
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Load
  input  wire logic        ld,
  input  wire logic [15:0] d,
  // Value
  output logic [15:0]      q
);

  // Keeps its reset value unless a complete load commits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= RESET;
    end else if (ld) begin
      q <= d;
    end
  end

endmodule

// ===== design/scl_loader.sv
// Power-on loader copying EEPROM configuration words into slave controller registers
`timescale 1ns/1ps
`include "scl_map.svh"
module scl_loader
  import scl_pkg::*;
#(
  parameter int TMO_CYC = `SCL_ACK_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // EEPROM word reader
  output scl_ee_req_t      ee_req,
  input  wire scl_ee_rsp_t ee_rsp,
  // Register read port, byte addressed
  input  wire logic        rd_en,
  input  wire logic [15:0] rd_addr,
  output logic [7:0]       rd_data,
  output logic             rd_valid,
  // Loader status
  output logic             load_busy,
  output logic             load_done,
  output logic             load_fail,
  // Loaded configuration
  output logic [15:0]      ifctl_q,
  output logic [15:0]      ifcfg_q,
  output logic [15:0]      synclen_q,
  output logic [15:0]      ifext_q,
  output logic [15:0]      alias_q
);

  localparam int NSLOT = 5;
  // Reset values indexed by EEPROM word number
  localparam logic [15:0] SLOT_RST [NSLOT] = '{`SCL_RST_IFCTL, `SCL_RST_IFCFG, `SCL_RST_SYNCLEN,
                                              `SCL_RST_IFEXT, `SCL_RST_ALIAS};
  localparam logic [11:0] TMO_MAX = 12'(TMO_CYC - 1);

  scl_state_t  state_reg;        // Sequence state
  scl_state_t  state_next;       // Next sequence state
  logic [2:0]  idx_reg;          // Word being read
  logic [11:0] tmo_reg;          // Cycles waited for the answer
  logic        req_reg;          // Request valid towards reader
  logic [15:0] sh_reg [NSLOT];   // Shadow copies until whole area is read
  logic [15:0] slot_q [NSLOT];   // Committed registers
  logic [7:0]  rd_data_reg;      // Read data flop
  logic        rd_valid_reg;     // Read answer flop

  // Sequence decode
  wire waiting  = (state_reg == ST_WAIT);
  wire got      = waiting && ee_rsp.ack;
  wire good     = got && !ee_rsp.err;
  wire timedout = waiting && !ee_rsp.ack && (tmo_reg == TMO_MAX);
  wire bad      = (got && ee_rsp.err) || timedout;
  wire commit   = good && (idx_reg == `SCL_WORD_LAST);
  wire store    = good && (idx_reg < `SCL_WORD_COPIED);  // Words 5..7 are not copied

  // Next state of the load sequence
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_ISSUE: state_next = ST_WAIT;
      ST_WAIT: begin
        if (bad) begin
          state_next = ST_FAIL;
        end else if (commit) begin
          state_next = ST_DONE;
        end else if (good) begin
          state_next = ST_ISSUE;
        end
      end
      ST_DONE:  state_next = ST_DONE;
      ST_FAIL:  state_next = ST_FAIL;
    endcase
  end

  // Runs once after reset; no software trigger needed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_ISSUE;
      idx_reg   <= `SCL_WORD_FIRST;
    end else begin
      state_reg <= state_next;
      if (good && !commit) begin
        idx_reg <= idx_reg + 3'h1;
      end
    end
  end

  // Request held from issue until answer or timeout
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_reg <= 1'b0;
    end else if (state_reg == ST_ISSUE) begin
      req_reg <= 1'b1;
    end else if (got || timedout) begin
      req_reg <= 1'b0;
    end
  end

  // Timeout so a dead reader cannot hang the loader
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmo_reg <= 12'h000;
    end else if (waiting && !ee_rsp.ack) begin
      tmo_reg <= tmo_reg + 12'h001;
    end else begin
      tmo_reg <= 12'h000;
    end
  end

  // Shadow capture; registers change only on a full clean pass
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NSLOT; i++) begin
        sh_reg[i] <= 16'h0000;
      end
    end else if (store) begin
      sh_reg[idx_reg] <= ee_rsp.data;
    end
  end

  // Committed configuration registers, words 0..4 in order
  for (genvar g = 0; g < NSLOT; g++) begin : g_slot
    scl_cfg_slot #(
      .RESET (SLOT_RST[g])
    ) u_slot (
      .clk (clk),
      .rst (rst),
      .ld  (commit),
      .d   (sh_reg[g]),
      .q   (slot_q[g])
    );
  end

  // Register read decode on word pairs, byte lane by address bit 0
  wire [15:0] rd_word = {rd_addr[15:1], 1'b0};
  wire        hit_ctl = (rd_word == `SCL_ADDR_IFCTL);
  wire        hit_cfg = (rd_word == `SCL_ADDR_IFCFG);
  wire        hit_syn = (rd_word == `SCL_ADDR_SYNCLEN);
  wire        hit_ext = (rd_word == `SCL_ADDR_IFEXT);
  wire        hit_als = (rd_word == `SCL_ADDR_ALIAS);
  wire [15:0] sel_w   = hit_ctl ? slot_q[0] :
                        hit_cfg ? slot_q[1] :
                        hit_syn ? slot_q[2] :
                        hit_ext ? slot_q[3] :
                        hit_als ? slot_q[4] : 16'h0000; // Unmapped reads zero
  wire [7:0]  sel_b   = rd_addr[0] ? sel_w[15:8] : sel_w[7:0];

  // Read answer one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_reg  <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_en;
      if (rd_en) begin
        rd_data_reg <= sel_b;
      end
    end
  end

  // Status flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_busy <= 1'b1;
      load_done <= 1'b0;
      load_fail <= 1'b0;
    end else begin
      load_busy <= (state_next == ST_ISSUE) || (state_next == ST_WAIT);
      load_done <= (state_next == ST_DONE);
      load_fail <= (state_next == ST_FAIL);
    end
  end

  // Outputs
  assign ee_req.valid = req_reg;
  assign ee_req.addr  = {3'h0, idx_reg};
  assign rd_data      = rd_data_reg;
  assign rd_valid     = rd_valid_reg;
  assign ifctl_q      = slot_q[0];
  assign ifcfg_q      = slot_q[1];
  assign synclen_q    = slot_q[2];
  assign ifext_q      = slot_q[3];
  assign alias_q      = slot_q[4];

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Request and word number stand until answered or timed out
  property p_req_holds;
    ee_req.valid && !ee_rsp.ack && !timedout |=> ee_req.valid && $stable(ee_req.addr);
  endproperty
  a_req_holds: assert property (p_req_holds) else $error("request dropped before answer");

  property p_ctl_load;
    commit |=> (ifctl_q == $past(sh_reg[0])) && load_done;
  endproperty
  a_ctl_load: assert property (p_ctl_load) else $error("word 0 not committed");

  property p_cfg_load;
    commit |=> (ifcfg_q == $past(sh_reg[1]));
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("word 1 not committed");

  property p_syn_load;
    commit |=> (synclen_q == $past(sh_reg[2]));
  endproperty
  a_syn_load: assert property (p_syn_load) else $error("word 2 not committed");

  property p_ext_load;
    commit |=> (ifext_q == $past(sh_reg[3]));
  endproperty
  a_ext_load: assert property (p_ext_load) else $error("word 3 not committed");

  property p_als_read;
    rd_en && (rd_addr == `SCL_ADDR_ALIAS) |=> rd_valid && (rd_data == $past(alias_q[7:0]));
  endproperty
  a_als_read: assert property (p_als_read) else $error("alias low byte read wrong");

  property p_fail_keeps;
    load_fail |-> (ifctl_q == `SCL_RST_IFCTL) && (synclen_q == `SCL_RST_SYNCLEN) && !load_done;
  endproperty
  a_fail_keeps: assert property (p_fail_keeps) else $error("failed load changed registers");

  property p_no_early_change;
    load_busy |-> (ifcfg_q == `SCL_RST_IFCFG) && (alias_q == `SCL_RST_ALIAS);
  endproperty
  a_no_early_change: assert property (p_no_early_change) else $error("register changed mid-load");

  property p_first_req;
    $fell(rst) |-> ##[1:3] ee_req.valid && (ee_req.addr == 6'h00);
  endproperty
  a_first_req: assert property (p_first_req) else $error("load did not start");

  c_done:    cover property (load_done);
  c_fail:    cover property (load_fail);
  c_timeout: cover property (timedout);

endmodule

// ===== verification/scl_ee_model.sv
// Behavioural model of the serial configuration EEPROM behind the loader
`timescale 1ns/1ps
module scl_ee_model
  import scl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Word read port
  input  wire scl_ee_req_t ee_req,
  output scl_ee_rsp_t      ee_rsp,
  // Bench controls
  input  wire logic [3:0]  delay,     // Wait cycles before answer
  input  wire logic [3:0]  err_word,  // Word answered with error, 4'hf none
  input  wire logic        mute       // Never answer
);
  // Fixed information area only; category data would follow at word 40h
  logic [15:0] mem [0:63];
  logic [3:0]  cnt;         // Answer delay counter
  logic        served;      // Word answered, wait for request to drop

  // Default content; bench overwrites words 0 to 4
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 16'h0000;
    mem[7]     = 16'h00d2;
    mem[6'h18] = 16'h1000;
    mem[6'h19] = 16'h0080;
    mem[6'h1a] = 16'h1400;
    mem[6'h1b] = 16'h0080;
    mem[6'h1c] = 16'h0004;
    mem[6'h3e] = 16'h000f;
    mem[6'h3f] = 16'h0001;
  end

  // One answer per request; data lines toggle when not answering
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ee_rsp <= '0;
      cnt    <= 4'h0;
      served <= 1'b0;
    end else begin
      ee_rsp.ack  <= 1'b0;
      ee_rsp.err  <= ~ee_rsp.err;   // Toggled every cycle without an answer, so never a stale value
      ee_rsp.data <= ~ee_rsp.data;
      if (!ee_req.valid) begin
        served <= 1'b0;
        cnt    <= 4'h0;
      end else if (!served && !mute) begin
        if (cnt == delay) begin
          ee_rsp.ack  <= 1'b1;
          ee_rsp.err  <= ee_req.addr == {2'h0, err_word};
          ee_rsp.data <= mem[ee_req.addr];
          served      <= 1'b1;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule

// ===== verification/scl_loader_bench.sv
// Self-checking bench for the configuration loader
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module scl_loader_bench
  import scl_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rd_en = 1'b0;
  logic [15:0] rd_addr = 16'h0000;
  logic [3:0]  delay = 4'h2;
  logic [3:0]  err_word = 4'hf;
  logic        mute = 1'b0;
  scl_ee_req_t ee_req;
  scl_ee_rsp_t ee_rsp;
  logic [7:0]  rd_data;
  logic        rd_valid, load_busy, load_done, load_fail;
  logic [15:0] ifctl_q, ifcfg_q, synclen_q, ifext_q, alias_q;
  int          error_cnt = 0;
  int          checked = 0;
  int          seen[$];   // Word numbers in answer order
  int          exp_w[5];  // Expected register values
  int          rst_w[5] = '{16'h0c08, 16'h6608, 16'h01f4, 16'h0000, 16'h0000};
  int          addr_w[5] = '{16'h0140, 16'h0150, 16'h0982, 16'h0152, 16'h0012};
  wire [79:0]  q_all = {alias_q, ifext_q, synclen_q, ifcfg_q, ifctl_q};

  // Short timeout keeps the no-answer case brief, yet above the slowest model answer
  scl_loader #(.TMO_CYC(16)) uut (.clk(clk), .rst(rst), .ee_req(ee_req), .ee_rsp(ee_rsp),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .load_busy(load_busy), .load_done(load_done), .load_fail(load_fail), .ifctl_q(ifctl_q),
    .ifcfg_q(ifcfg_q), .synclen_q(synclen_q), .ifext_q(ifext_q), .alias_q(alias_q));
  scl_ee_model ee (.clk(clk), .rst(rst), .ee_req(ee_req), .ee_rsp(ee_rsp),
    .delay(delay), .err_word(err_word), .mute(mute));

  // 25 MHz clock
  always #20 clk = ~clk;

  // Record each answered word
  always @(negedge clk) if (ee_req.valid === 1'b1 && ee_rsp.ack === 1'b1) seen.push_back(ee_req.addr);

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One byte read, answer one cycle later
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    `CHK(rd_valid, 1'b1)
    `CHK(rd_data, e)
  endtask

  // All five registers, both bytes, plus an unmapped place
  task automatic check_regs();
    for (int i = 0; i < 5; i++) begin
      `CHK(q_all[i*16 +: 16], exp_w[i][15:0])
      rd_chk(addr_w[i][15:0], exp_w[i][7:0]);
      rd_chk(addr_w[i][15:0] + 16'h0001, exp_w[i][15:8]);
    end
    rd_chk(16'h0144, 8'h00);
  endtask

  // Kind 0 clean load, 1 error answer, 2 no answer
  task automatic run_one(input int kind);
    int n;
    n = 0;
    seen.delete();
    rst = 1'b1;
    delay = 4'($urandom_range(9, 2));
    err_word = kind == 1 ? 4'($urandom_range(7, 0)) : 4'hf;
    mute = kind == 2;
    for (int i = 0; i < 5; i++) exp_w[i] = rst_w[i];
    repeat (4) @(negedge clk);
    // Content changes only while the loader is held in reset
    for (int i = 0; i < 5; i++) ee.mem[i] = 16'($urandom);
    rst = 1'b0;
    // Reset values hold while the load runs
    check_regs();
    while (load_busy === 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    `CHK(load_busy, 1'b0)
    `CHK(load_done, kind == 0)
    `CHK(load_fail, kind != 0)
    // Only a clean load moves the registers
    if (kind == 0) begin
      for (int i = 0; i < 5; i++) exp_w[i] = ee.mem[i];
      `CHK(seen.size(), 8)
      foreach (seen[i]) `CHK(seen[i], i)
    end
    check_regs();
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'h53d1));
    for (int t = 0; t < 6; t++) run_one(t < 3 ? 0 : (t < 5 ? 1 : 2));
    tally_and_finish();
  end

  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    #(40 * 5000);
    error_cnt++;
    tally_and_finish();
  end
endmodule
